// ### fsl_pkg.sv
// Purpose: Shared constants and types for the flash security and option load block
// Assumes: APB register bus, 32-bit data, one word per register index
// Notes: Byte address of a register is four times its index
`default_nettype none
package fsl_pkg;
   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int ADDR_W = 18;
   localparam int IDX_W = 16;
   localparam int KEY_BYTES = 8;

   // ************************************************************
   // Register indices (byte address = index * 4)
   // ************************************************************
   localparam logic [15:0] FLASH_CLOCK_DIVIDER_IDX = 16'h1820;
   localparam logic [15:0] FLASH_OPTION_WORKING_IDX = 16'h1821;
   localparam logic [15:0] FLASH_CONFIG_IDX = 16'h1823;
   localparam logic [15:0] FLASH_PROTECT_WORKING_IDX = 16'h1824;
   localparam logic [15:0] FLASH_STATUS_IDX = 16'h1825;
   localparam logic [15:0] FLASH_COMMAND_IDX = 16'h1826;
   localparam logic [15:0] SECURITY_STATE_IDX = 16'h1830;
   localparam logic [15:0] STORED_FINE_TRIM_IDX = 16'hFFAE;
   localparam logic [15:0] STORED_OSC_TRIM_IDX = 16'hFFAF;
   localparam logic [15:0] BACKDOOR_COMPARE_KEY_IDX = 16'hFFB0;
   localparam logic [15:0] NONVOLATILE_PROTECT_BYTE_IDX = 16'hFFBD;
   localparam logic [15:0] NONVOLATILE_OPTION_BYTE_IDX = 16'hFFBF;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int OPT_KEY_ENABLE = 7;
   localparam int OPT_VECTOR_REDIRECT_DISABLE = 6;
   localparam int DIV_DIVIDER_LOADED = 7;
   localparam int CFG_KEY_ACCESS_ENABLE = 5;
   localparam int STAT_COMMAND_BUFFER_EMPTY = 7;
   localparam int STAT_COMMAND_COMPLETE = 6;
   localparam int STAT_ACCESS_ERROR = 4;
   localparam int ST_SECURED = 0;
   localparam int ST_KEY_UNLOCKED = 1;
   localparam int ST_ERASE_UNLOCKED = 2;
   localparam int ST_RAM_UNINIT = 3;
   localparam int ST_KEY_MISMATCH = 4;

   // ************************************************************
   // Codes and reset values
   // ************************************************************
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [7:0] OPTION_RESET = 8'h00;
   localparam logic [7:0] PROTECT_RESET = 8'hFF;
   localparam logic [15:0] DIRECT_PAGE_LIMIT = 16'h0100;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic from_debug;
      logic from_nonsecure;
   } fsl_ram_req_t;

   typedef struct packed {
      logic deny;
      logic grant;
      logic direct_page;
   } fsl_ram_ans_t;
endpackage : fsl_pkg
`default_nettype wire

// ### fsl_key_cmp.sv
// Purpose: Collects eight backdoor key bytes and compares them with the stored key
// Assumes: Byte strobes come from logic on the same clock
// Notes: Result pulses two cycles after the strobe of the last missing byte
`timescale 1ns/1ps
`default_nettype none
module fsl_key_cmp #(
   parameter int NBYTES = fsl_pkg::KEY_BYTES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic byte_we,
   input wire logic [2:0] byte_sel,
   input wire logic [7:0] byte_data,
   input wire logic [NBYTES*8-1:0] stored_key,
   output logic match,
   output logic mismatch
);
   import fsl_pkg::*;

   logic [NBYTES*8-1:0] entered;
   logic [NBYTES-1:0] seen;
   logic [NBYTES-1:0] next_seen;

   // Mask after this write
   always_comb begin
      next_seen = seen;
      if (byte_we) begin
         next_seen[byte_sel] = 1'b1;
      end
   end

   // Per-byte capture of the entered key
   for (genvar b = 0; b < NBYTES; b++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            entered[b*8 +: 8] <= 8'h00;
         end else if (ce && byte_we && byte_sel == 3'(b)) begin
            entered[b*8 +: 8] <= byte_data;
         end
      end
   end

   // Completion tracking and compare
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= '0;
         match <= 1'b0;
         mismatch <= 1'b0;
      end else if (ce) begin
         match <= 1'b0;
         mismatch <= 1'b0;
         if (&seen) begin
            seen <= '0;
            match <= (entered == stored_key);
            mismatch <= (entered != stored_key);
         end else begin
            seen <= next_seen;
         end
      end
   end
endmodule : fsl_key_cmp
`default_nettype wire

// ### fsl_top.sv
// Purpose: Flash security, option load, backdoor key and RAM gating behind APB
// Assumes: Nonvolatile bytes are presented on inputs by the flash array
// Notes: Zero-latency decode, pready rises one cycle into the access phase
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fsl_top #(
   parameter int KEY_N = fsl_pkg::KEY_BYTES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fsl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] pprot,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic debug_access,
   input wire logic [7:0] nv_protect,
   input wire logic [7:0] nv_option,
   input wire logic [7:0] nv_fine_trim,
   input wire logic [7:0] nv_osc_trim,
   input wire logic [KEY_N*8-1:0] nv_key,
   input wire logic power_on,
   input wire logic deep_stop_wake,
   input wire logic erase_blank_ok,
   input wire fsl_pkg::fsl_ram_req_t ram_req,
   output fsl_pkg::fsl_ram_ans_t ram_ans,
   output logic secured
);
   import fsl_pkg::*;

   // ************************************************************
   // Working registers and state
   // ************************************************************
   logic loaded;
   logic [7:0] flash_option_working;
   logic [7:0] flash_protect_working;
   logic [7:0] flash_clock_divider;
   logic [7:0] flash_config;
   logic [7:0] flash_command;
   logic [7:0] fine_trim;
   logic [7:0] osc_trim;
   logic [KEY_N*8-1:0] backdoor_compare_key;
   logic access_error;
   logic key_unlocked;
   logic erase_unlocked;
   logic key_mismatch;
   logic ram_uninit;
   logic key_match;
   logic key_miss;

   // ************************************************************
   // APB decode
   // ************************************************************
   logic [IDX_W-1:0] idx;
   logic xfer;
   logic wr;
   logic is_key;
   logic key_ok;
   logic key_we;
   logic mapped;
   logic [7:0] rd_byte;
   logic [1:0] sec_bits;
   logic next_secured;

   assign idx = paddr[ADDR_W-1:2];
   assign xfer = psel && penable && pready;
   assign wr = xfer && pwrite;
   assign is_key = (idx[IDX_W-1:3] == BACKDOOR_COMPARE_KEY_IDX[IDX_W-1:3]);
   // Key path open only to secure code with both enables set
   assign key_ok = flash_option_working[OPT_KEY_ENABLE] && flash_config[CFG_KEY_ACCESS_ENABLE]
                   && !pprot[1] && !debug_access;
   assign key_we = wr && is_key && key_ok;
   assign sec_bits = flash_option_working[1:0];
   assign next_secured = (sec_bits != SEC_UNSECURED) && !key_unlocked && !erase_unlocked;

   // Read mux and map check
   always_comb begin
      rd_byte = 8'h00;
      mapped = 1'b1;
      unique case (idx)
         FLASH_CLOCK_DIVIDER_IDX: rd_byte = flash_clock_divider;
         FLASH_OPTION_WORKING_IDX: rd_byte = flash_option_working;
         FLASH_CONFIG_IDX: rd_byte = flash_config & (8'h01 << CFG_KEY_ACCESS_ENABLE);
         FLASH_PROTECT_WORKING_IDX: rd_byte = flash_protect_working;
         FLASH_STATUS_IDX: rd_byte = {2'h3, 1'b0, access_error, 4'h0};
         FLASH_COMMAND_IDX: rd_byte = flash_command;
         SECURITY_STATE_IDX: rd_byte = {3'h0, key_mismatch, ram_uninit, erase_unlocked, key_unlocked, secured};
         STORED_FINE_TRIM_IDX: rd_byte = {7'h00, fine_trim[0]};
         STORED_OSC_TRIM_IDX: rd_byte = osc_trim;
         NONVOLATILE_PROTECT_BYTE_IDX: rd_byte = nv_protect;
         NONVOLATILE_OPTION_BYTE_IDX: rd_byte = nv_option;
         default: mapped = is_key && pwrite && key_ok; // Key bytes are write-only
      endcase
   end

   // Bus answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= !mapped;
         end
      end
   end

   // ************************************************************
   // Reset-time load of nonvolatile bytes
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded <= 1'b0;
         flash_option_working <= OPTION_RESET;
         flash_protect_working <= PROTECT_RESET;
         fine_trim <= 8'h00;
         osc_trim <= 8'h00;
         backdoor_compare_key <= '0;
      end else if (ce) begin
         if (!loaded) begin
            loaded <= 1'b1;
            flash_option_working <= nv_option;
            flash_protect_working <= nv_protect;
            fine_trim <= nv_fine_trim;
            osc_trim <= nv_osc_trim;
            backdoor_compare_key <= nv_key;
         end else if (wr && idx == FLASH_PROTECT_WORKING_IDX) begin
            flash_protect_working <= pwdata[7:0];
         end
      end
   end

   // ************************************************************
   // Software registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_clock_divider <= 8'h00;
         flash_config <= 8'h00;
         flash_command <= 8'h00;
      end else if (ce) begin
         // Divider writes once, not while an access error stands
         if (wr && idx == FLASH_CLOCK_DIVIDER_IDX && !flash_clock_divider[DIV_DIVIDER_LOADED] && !access_error) begin
            flash_clock_divider <= {1'b1, pwdata[6:0]};
         end
         if (wr && idx == FLASH_CONFIG_IDX) begin
            flash_config <= pwdata[7:0] & (8'h01 << CFG_KEY_ACCESS_ENABLE);
         end
         if (wr && idx == FLASH_COMMAND_IDX) begin
            flash_command <= pwdata[7:0];
         end
      end
   end

   // Access error: refused key write sets it, write one clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         access_error <= 1'b0;
      end else if (ce) begin
         if (wr && is_key && !key_ok) begin
            access_error <= 1'b1;
         end else if (wr && idx == FLASH_STATUS_IDX && pwdata[STAT_ACCESS_ERROR]) begin
            access_error <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Backdoor key compare
   // ************************************************************
   fsl_key_cmp #(
      .NBYTES(KEY_N)
   ) u_key (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .byte_we(key_we),
      .byte_sel(idx[2:0]),
      .byte_data(pwdata[7:0]),
      .stored_key(backdoor_compare_key),
      .match(key_match),
      .mismatch(key_miss)
   );

   // ************************************************************
   // Security state
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_unlocked <= 1'b0;
         erase_unlocked <= 1'b0;
         key_mismatch <= 1'b0;
         secured <= 1'b1;
      end else if (ce) begin
         if (key_match && flash_option_working[OPT_KEY_ENABLE]) begin
            key_unlocked <= 1'b1;
         end
         if (erase_blank_ok) begin
            erase_unlocked <= 1'b1;
         end
         if (key_miss) begin
            key_mismatch <= 1'b1;
         end else if (wr && idx == SECURITY_STATE_IDX && pwdata[ST_KEY_MISMATCH]) begin
            key_mismatch <= 1'b0;
         end
         secured <= loaded ? next_secured : 1'b1;
      end
   end

   // ************************************************************
   // RAM gating and retention status
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_ans <= '0;
      end else if (ce) begin
         ram_ans.deny <= ram_req.valid && secured
                         && (ram_req.from_debug || ram_req.from_nonsecure);
         ram_ans.grant <= ram_req.valid && !(secured
                         && (ram_req.from_debug || ram_req.from_nonsecure));
         ram_ans.direct_page <= ram_req.valid && (ram_req.addr < DIRECT_PAGE_LIMIT);
      end
   end

   // Uninitialised flag survives reset; set by power-on or deep stop wake
   always_ff @(posedge pclk) begin
      if (ce) begin
         if (power_on || deep_stop_wake) begin
            ram_uninit <= 1'b1;
         end else if (wr && idx == SECURITY_STATE_IDX && pwdata[ST_RAM_UNINIT]) begin
            ram_uninit <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_load_option: assert property (ce && !loaded |=> flash_option_working == $past(nv_option))
      else $error("option byte not loaded");
   chk_load_key: assert property (ce && !loaded |=> backdoor_compare_key == $past(nv_key))
      else $error("key not loaded");
   chk_key_unlock: assert property (ce && key_match && flash_option_working[OPT_KEY_ENABLE]
                                    |=> key_unlocked)
      else $error("key match did not unlock");
   chk_debug_key_refused: assert property (wr && is_key && debug_access |-> !key_we)
      else $error("debug reached key path");
   chk_key_enable_off: assert property (!flash_option_working[OPT_KEY_ENABLE] |-> !key_we)
      else $error("key entry with key disabled");
   chk_unsecure_pattern: assert property (ce && loaded && sec_bits == SEC_UNSECURED
                                          |=> !secured)
      else $error("unsecured pattern left device secured");
   chk_ram_block: assert property (ce && secured && ram_req.valid && ram_req.from_debug
                                   |=> ram_ans.deny && !ram_ans.grant)
      else $error("secure RAM reached by debug");
   chk_ram_uninit: assert property (ce && (power_on || deep_stop_wake) |=> ram_uninit)
      else $error("uninitialised flag missing");
   chk_key_refused_err: assert property (ce && wr && is_key && !key_ok |=> access_error)
      else $error("refused key write left no access error");
   chk_ready_answer: assert property (ce && psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   chk_direct_page: assert property (ce && ram_req.valid && ram_req.addr < DIRECT_PAGE_LIMIT
                                     |=> ram_ans.direct_page)
      else $error("direct page flag missing");
   chk_other_secure: assert property (ce && loaded && sec_bits != SEC_UNSECURED && !key_unlocked
                                      && !erase_unlocked |=> secured)
      else $error("device unsecured by other pattern");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");

   cov_key_unlock: cover property (key_match ##2 !secured);
   cov_ram_denied: cover property (ram_ans.deny);
   cov_erase_unlock: cover property (erase_blank_ok ##[1:2] !secured);
endmodule : fsl_top
`default_nettype wire

// ### fsl_cpu_model.sv
// Purpose: CPU bus master and background debug port model facing the block
// Assumes: Slave answers on pready sampled at rising edges of pclk
// Notes: After the time-zero idle levels, every signal changes by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module fsl_cpu_model
   import fsl_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [fsl_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [2:0] pprot,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic debug_access,
   output fsl_pkg::fsl_ram_req_t ram_req,
   input wire fsl_pkg::fsl_ram_ans_t ram_ans,
   output logic hung
);
   // ************************************************************
   // Idle levels at time zero
   // ************************************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pprot = 3'h0;
      debug_access = 1'b0;
      ram_req = '0;
      hung = 1'b0;
   end

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] data, input logic nonsec,
                      input logic dbg, output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, data};
      pprot <= {1'b0, nonsec, 1'b0};
      debug_access <= dbg;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         hung <= 1'b1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One RAM request; answer taken one cycle after it is sampled
   task automatic ram(input logic [15:0] a, input logic dbg, input logic ns, output fsl_ram_ans_t ans);
      @(posedge pclk);
      ram_req <= '{1'b1, a, dbg, ns};
      @(posedge pclk);
      ram_req.valid <= 1'b0;
      @(posedge pclk);
      ans = ram_ans;
   endtask : ram
endmodule : fsl_cpu_model
`default_nettype wire

// ### flash_security_option_load_tb_top.sv
// Purpose: Self-checking bench for option load, backdoor key and RAM gating
// Assumes: Design answers APB one cycle into the access phase
// Notes: Random protect, trim and key contents from a fixed seed; option byte set per test
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
   $display("unexpected at %0t got %0h expected %0h", $time, got, exp); end end
module flash_security_option_load_tb_top;
   import fsl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, debug_access, secured, hung;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [2:0] pprot;
   logic [7:0] nv_protect, nv_option, nv_fine_trim, nv_osc_trim;
   logic [63:0] nv_key;
   logic power_on, deep_stop_wake, erase_blank_ok, e;
   fsl_ram_req_t ram_req;
   fsl_ram_ans_t ram_ans, ans;
   int fails = 0;
   int num_checks = 0;

   // ************************************************************
   // Clock, design and bus partner
   // ************************************************************
   always #10 pclk = ~pclk;
   fsl_top i_fsl_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .debug_access(debug_access), .nv_protect(nv_protect), .nv_option(nv_option),
      .nv_fine_trim(nv_fine_trim), .nv_osc_trim(nv_osc_trim), .nv_key(nv_key), .power_on(power_on),
      .deep_stop_wake(deep_stop_wake), .erase_blank_ok(erase_blank_ok), .ram_req(ram_req),
      .ram_ans(ram_ans), .secured(secured));
   fsl_cpu_model i_fsl_cpu_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .debug_access(debug_access), .ram_req(ram_req), .ram_ans(ram_ans), .hung(hung));

   // ************************************************************
   // Expectations and helpers
   // ************************************************************
   function automatic logic exp_sec(input logic [7:0] opt);
      return opt[1:0] !== SEC_UNSECURED;
   endfunction : exp_sec

   function automatic fsl_ram_ans_t exp_ans(input logic sec, input logic [15:0] a, input logic dbg,
                                            input logic ns);
      logic dn;
      dn = sec & (dbg | ns);
      return '{dn, ~dn, a < DIRECT_PAGE_LIMIT};
   endfunction : exp_ans

   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [15:0] i, input logic [7:0] v, input logic ns, input logic dbg);
      i_fsl_cpu_model.apb(1'b1, i, v, ns, dbg, d, e);
   endtask : wr

   task automatic rd(input logic [15:0] i);
      i_fsl_cpu_model.apb(1'b0, i, 8'h00, 1'b0, 1'b0, d, e);
   endtask : rd

   task automatic do_reset(input logic [7:0] opt);
      @(posedge pclk);
      nv_option <= opt;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : do_reset

   task automatic key_all(input logic [63:0] k);
      wr(FLASH_STATUS_IDX, 8'h10, 1'b0, 1'b0);
      wr(FLASH_CONFIG_IDX, 8'h20, 1'b0, 1'b0);
      for (int i = 7; i >= 0; i--) begin
         wr(BACKDOOR_COMPARE_KEY_IDX + 16'(i), k[8*i +: 8], 1'b0, 1'b0);
      end
   endtask : key_all

   task automatic wait_sec(input logic exp);
      for (int n = 0; n < 10 && secured !== exp; n++) begin
         @(posedge pclk);
      end
   endtask : wait_sec

   // Hang guards
   always @(posedge hung) begin
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      report_and_stop();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(32'hD10C));
      nv_protect = 8'($urandom);
      nv_option = 8'h82;
      nv_fine_trim = 8'($urandom);
      nv_osc_trim = 8'($urandom);
      nv_key = {$urandom, $urandom};
      power_on = 1'b1;
      deep_stop_wake = 1'b0;
      erase_blank_ok = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      power_on <= 1'b0;
      do_reset(8'h82);
      `CHK(secured, 1'b0)
      rd(FLASH_OPTION_WORKING_IDX);
      `CHK(d, 32'h00000082)
      rd(FLASH_PROTECT_WORKING_IDX);
      `CHK(d, {24'h000000, nv_protect})
      rd(STORED_OSC_TRIM_IDX);
      `CHK(d, {24'h000000, nv_osc_trim})
      rd(STORED_FINE_TRIM_IDX);
      `CHK(d, {31'h00000000, nv_fine_trim[0]})
      rd(16'h1822);
      `CHK(e, 1'b1)
      rd(BACKDOOR_COMPARE_KEY_IDX);
      `CHK(e, 1'b1)
      // RAM flag: set at power-on, cleared by software, kept over reset, set by deep wake
      rd(SECURITY_STATE_IDX);
      `CHK(d[ST_RAM_UNINIT], 1'b1)
      wr(SECURITY_STATE_IDX, 8'h08, 1'b0, 1'b0);
      do_reset(8'h82);
      rd(SECURITY_STATE_IDX);
      `CHK(d[ST_RAM_UNINIT], 1'b0)
      @(posedge pclk);
      deep_stop_wake <= 1'b1;
      @(posedge pclk);
      deep_stop_wake <= 1'b0;
      rd(SECURITY_STATE_IDX);
      `CHK(d[ST_RAM_UNINIT], 1'b1)
      // Every security pattern, with RAM gating at the direct-page boundary
      for (int s = 0; s < 4; s++) begin
         do_reset({6'h20, 2'(s)});
         `CHK(secured, exp_sec({6'h20, 2'(s)}))
         for (int r = 0; r < 4; r++) begin
            i_fsl_cpu_model.ram(16'h00FF + 16'(r % 2), r[1], r[0], ans);
            `CHK(ans, exp_ans(secured, 16'h00FF + 16'(r % 2), r[1], r[0]))
         end
      end
      for (int r = 0; r < 6; r++) begin
         d = $urandom;
         i_fsl_cpu_model.ram(d[15:0], d[16], d[17], ans);
         `CHK(ans, exp_ans(1'b1, d[15:0], d[16], d[17]))
      end
      // Key from debug and non-secure code refused, then a wrong key
      do_reset(8'h80);
      wr(FLASH_CONFIG_IDX, 8'h20, 1'b0, 1'b0);
      wr(BACKDOOR_COMPARE_KEY_IDX, nv_key[7:0], 1'b0, 1'b1);
      `CHK(e, 1'b1)
      wr(BACKDOOR_COMPARE_KEY_IDX, nv_key[7:0], 1'b1, 1'b0);
      `CHK(e, 1'b1)
      key_all(nv_key ^ 64'h1);
      repeat (4) @(posedge pclk);
      `CHK(secured, 1'b1)
      rd(SECURITY_STATE_IDX);
      `CHK(d[ST_KEY_MISMATCH], 1'b1)
      // Correct key in reverse byte order lifts security until reset
      key_all(nv_key);
      wait_sec(1'b0);
      `CHK(secured, 1'b0)
      i_fsl_cpu_model.ram(16'h0080, 1'b1, 1'b0, ans);
      `CHK(ans, exp_ans(1'b0, 16'h0080, 1'b1, 1'b0))
      do_reset(8'h80);
      `CHK(secured, 1'b1)
      // Key disabled: only erase and blank verify unsecures
      do_reset(8'h00);
      key_all(nv_key);
      repeat (4) @(posedge pclk);
      `CHK(secured, 1'b1)
      @(posedge pclk);
      ce <= 1'b0;
      erase_blank_ok <= 1'b1;
      @(posedge pclk);
      erase_blank_ok <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(secured, 1'b1)
      ce <= 1'b1;
      @(posedge pclk);
      erase_blank_ok <= 1'b1;
      @(posedge pclk);
      erase_blank_ok <= 1'b0;
      wait_sec(1'b0);
      `CHK(secured, 1'b0)
      do_reset(8'h00);
      `CHK(secured, 1'b1)
      report_and_stop();
   end
endmodule : flash_security_option_load_tb_top
`default_nettype wire
